/* spwc_regs.svh */
// Purpose: Named constants for the power-state and wake controller
// Assumes: 20 MHz clock, 50 ns period
// Notes: Times are held in their own unit; cycle counts derive from them
`ifndef SPWC_REGS_SVH
`define SPWC_REGS_SVH

`define SPWC_CLK_HZ 20000000
`define SPWC_SHORT_SEC 4
`define SPWC_LONG_SEC 6
`define SPWC_DEB_US 10000
`define SPWC_TICK_HZ 1000
// One millisecond tick from the 20 MHz clock
`define SPWC_TICK_CYC (`SPWC_CLK_HZ / `SPWC_TICK_HZ)
`define SPWC_SHORT_MS (`SPWC_SHORT_SEC * `SPWC_TICK_HZ)
`define SPWC_LONG_MS (`SPWC_LONG_SEC * `SPWC_TICK_HZ)
`define SPWC_DEB_MS (`SPWC_DEB_US / 1000)

// Wake source bit positions
`define SPWC_WK_SWITCH 0
`define SPWC_WK_RTC 1
`define SPWC_WK_LAN 2
`define SPWC_WK_USB 3
`define SPWC_WK_PCIE 4
`define SPWC_WK_IR 5
`define SPWC_WK_N 6

// Indicator codes
`define SPWC_LED_OFF 2'h0
`define SPWC_LED_PRIMARY 2'h1
`define SPWC_LED_SECONDARY 2'h2

`endif

/* spwc_pkg.sv */
// Purpose: Types for the power-state and wake controller
// Assumes: Nothing beyond the constants header
// Notes: States follow the sleeping and working global states
package spwc_pkg;
	typedef enum logic [2:0] {
		SPWC_S0 = 3'b000,
		SPWC_S3 = 3'b001,
		SPWC_S4 = 3'b010,
		SPWC_S5 = 3'b011,
		SPWC_G3 = 3'b100
	} spwc_state_t;

	typedef enum logic [1:0] {
		SPWC_PRESS_NONE = 2'b00,
		SPWC_PRESS_SHORT = 2'b01,
		SPWC_PRESS_MID = 2'b10,
		SPWC_PRESS_LONG = 2'b11
	} spwc_press_t;
endpackage : spwc_pkg

/* spwc_tick.sv */
// Purpose: Millisecond enable pulse divider
// Assumes: Single clock, synchronous reset
// Notes: One-cycle pulse every TICK_CYC clocks
`timescale 1ns/1ns
`default_nettype none
`include "spwc_regs.svh"
module spwc_tick #(
	parameter int TICK_CYC = `SPWC_TICK_CYC
) (
	input wire logic clk, // clock
	input wire logic sys_rst, // sync reset
	output logic tick // one-cycle enable
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_q == 16'(TICK_CYC - 1)) begin
			cnt_q <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule : spwc_tick
`default_nettype wire

/* spwc_press.sv */
// Purpose: Debounce the power switch and classify each press by length
// Assumes: Switch level active high, synchronous to clk
// Notes: Long result fires while still held, so forced off needs no release
`timescale 1ns/1ns
`default_nettype none
`include "spwc_regs.svh"
module spwc_press
	import spwc_pkg::*;
#(
	parameter int DEB_MS = `SPWC_DEB_MS,
	parameter int SHORT_MS = `SPWC_SHORT_MS,
	parameter int LONG_MS = `SPWC_LONG_MS
) (
	input wire logic clk, // clock
	input wire logic sys_rst, // sync reset
	input wire logic tick, // millisecond enable
	input wire logic switch_raw, // raw switch level
	output logic pressed, // debounced level
	output spwc_press_t press_kind, // classification
	output logic press_valid // one-cycle result pulse
);
	logic [7:0] deb_q;
	logic [12:0] hold_q;
	logic long_done_q;
	logic raw_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			raw_q <= 1'b0;
			deb_q <= 8'h00;
			pressed <= 1'b0;
		end else begin
			raw_q <= switch_raw;
			if (raw_q == pressed) begin
				deb_q <= 8'h00;
			end else if (tick) begin
				if (deb_q == 8'(DEB_MS - 1)) begin
					pressed <= raw_q;
					deb_q <= 8'h00;
				end else begin
					deb_q <= deb_q + 8'h01;
				end
			end
		end
	end

	// Duration runs from debounced press to debounced release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_q <= 13'h0000;
			long_done_q <= 1'b0;
			press_valid <= 1'b0;
			press_kind <= SPWC_PRESS_NONE;
		end else begin
			press_valid <= 1'b0;
			if (pressed) begin
				if (tick && hold_q != 13'h1FFF) begin
					hold_q <= hold_q + 13'h0001;
				end
				if (!long_done_q && hold_q > 13'(LONG_MS)) begin
					long_done_q <= 1'b1;
					press_valid <= 1'b1;
					press_kind <= SPWC_PRESS_LONG;
				end
			end else if (hold_q != 13'h0000) begin
				hold_q <= 13'h0000;
				long_done_q <= 1'b0;
				if (!long_done_q) begin
					press_valid <= 1'b1;
					press_kind <= (hold_q < 13'(SHORT_MS)) ? SPWC_PRESS_SHORT
						: SPWC_PRESS_MID;
				end
			end
		end
	end
endmodule : spwc_press
`default_nettype wire

/* spwc_ctrl.sv */
// Purpose: System power-state and wake controller
// Assumes: Inputs synchronous to clk; 20 MHz clock
// Notes: Policy bits are plain inputs; no software registers
`timescale 1ns/1ns
`default_nettype none
`include "spwc_regs.svh"
module spwc_ctrl
	import spwc_pkg::*;
#(
	parameter int TICK_CYC = `SPWC_TICK_CYC,
	parameter int DEB_MS = `SPWC_DEB_MS,
	parameter int SHORT_MS = `SPWC_SHORT_MS,
	parameter int LONG_MS = `SPWC_LONG_MS
) (
	input wire logic clk, // 20 MHz clock
	input wire logic sys_rst, // sync reset, high
	input wire logic ac_good, // AC mains present
	input wire logic switch_raw, // power switch, high when pressed
	input wire logic os_sleep_req, // OS requests sleep entry
	input wire logic os_sleep_s4, // sleep request targets S4
	input wire logic os_off_req, // OS requests soft-off
	input wire logic policy_button_off, // short press goes to soft-off
	input wire logic restore_last, // restore prior on/off state after AC loss
	input wire logic restore_always_on, // power on after AC loss
	input wire logic usb_deep_wake_en, // firmware USB wake from S4/S5
	input wire logic deep_standby, // deepest standby active
	input wire logic rtc_alarm, // RTC alarm, incl. programmed wake time
	input wire logic lan_wake_frame, // network wake frame seen
	input wire logic usb_activity, // USB bus activity
	input wire logic pcie_wake_n, // PCIe wake, low active
	input wire logic ir_activity, // infrared receiver activity
	input wire logic radio_event, // short-range radio event, ignored
	input wire logic dual_led, // indicator is dual colour
	output spwc_state_t sys_state, // current power state
	output logic main_power_on, // main rails enabled
	output logic resume_ctx, // one-cycle pulse, resume from RAM
	output logic cold_boot, // one-cycle pulse, cold boot
	output logic monitor_on, // display monitor powered
	output logic [1:0] led_code // indicator colour
);
	logic tick;
	logic pressed;
	spwc_press_t press_kind;
	logic press_valid;
	logic last_on_q;
	logic after_g3_q;
	logic [`SPWC_WK_N-1:0] wake_vec;
	logic wake_any;
	logic wake_rtc_only;
	spwc_state_t state_d;

	spwc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick)
	);

	spwc_press #(.DEB_MS(DEB_MS), .SHORT_MS(SHORT_MS), .LONG_MS(LONG_MS)) u_press (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.switch_raw(switch_raw),
		.pressed(pressed),
		.press_kind(press_kind),
		.press_valid(press_valid)
	);

	function automatic logic is_sleep(input spwc_state_t s);
		is_sleep = (s == SPWC_S3) || (s == SPWC_S4) || (s == SPWC_S5);
	endfunction : is_sleep

	// ************************************************
	// Wake sources
	// ************************************************
	// Radio input is deliberately left out of the vector
	always_comb begin
		wake_vec = '0;
		// Only a short result counts as a switch wake; long goes to soft-off
		wake_vec[`SPWC_WK_SWITCH] = press_valid && press_kind == SPWC_PRESS_SHORT;
		wake_vec[`SPWC_WK_RTC] = rtc_alarm;
		wake_vec[`SPWC_WK_LAN] = lan_wake_frame;
		wake_vec[`SPWC_WK_PCIE] = !pcie_wake_n;
		wake_vec[`SPWC_WK_IR] = ir_activity && !deep_standby;
		// After a mechanical off the USB rail may be unpowered, so stay deaf
		if (sys_state == SPWC_S3) begin
			wake_vec[`SPWC_WK_USB] = usb_activity && !after_g3_q;
		end else begin
			wake_vec[`SPWC_WK_USB] = usb_activity && usb_deep_wake_en
				&& !after_g3_q && !deep_standby;
		end
		if (!is_sleep(sys_state)) begin
			wake_vec = '0;
		end
	end

	assign wake_any = |wake_vec;
	assign wake_rtc_only = wake_vec == (`SPWC_WK_N'(1) << `SPWC_WK_RTC);

	// ************************************************
	// State machine
	// ************************************************
	always_comb begin
		state_d = sys_state;
		unique case (sys_state)
			SPWC_G3: begin
				// Restore policy on AC return
				if (ac_good) begin
					state_d = (restore_always_on || (restore_last && last_on_q))
						? SPWC_S0 : SPWC_S5;
				end
			end
			SPWC_S0: begin
				// Long press first so a hung system can always be forced off
				if (press_valid && press_kind == SPWC_PRESS_LONG) begin
					state_d = SPWC_S5;
				end else if (press_valid && press_kind == SPWC_PRESS_SHORT) begin
					state_d = policy_button_off ? SPWC_S5 : SPWC_S3;
				end else if (os_off_req) begin
					state_d = SPWC_S5;
				end else if (os_sleep_req) begin
					state_d = os_sleep_s4 ? SPWC_S4 : SPWC_S3;
				end
			end
			SPWC_S3, SPWC_S4, SPWC_S5: begin
				if (press_valid && press_kind == SPWC_PRESS_LONG) begin
					state_d = SPWC_S5;
				end else if (press_valid && press_kind == SPWC_PRESS_SHORT) begin
					state_d = SPWC_S0;
				end else if (wake_any) begin
					state_d = SPWC_S0;
				end
			end
		endcase
		if (!ac_good) begin
			state_d = SPWC_G3;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sys_state <= SPWC_G3;
		end else begin
			sys_state <= state_d;
		end
	end

	// Remember on/off for the restore policy; G3 itself leaves it alone
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			last_on_q <= 1'b0;
			after_g3_q <= 1'b0;
		end else begin
			if (sys_state != SPWC_G3) begin
				last_on_q <= (sys_state == SPWC_S0);
			end
			if (sys_state == SPWC_G3) begin
				after_g3_q <= 1'b1;
			end else if (sys_state == SPWC_S0) begin
				after_g3_q <= 1'b0;
			end
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	// Outputs follow state_d so each port is a flop yet tracks sys_state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			main_power_on <= 1'b0;
			resume_ctx <= 1'b0;
			cold_boot <= 1'b0;
			monitor_on <= 1'b0;
			led_code <= `SPWC_LED_OFF;
		end else begin
			main_power_on <= (state_d == SPWC_S0);
			resume_ctx <= (sys_state == SPWC_S3) && (state_d == SPWC_S0);
			cold_boot <= (sys_state != SPWC_S3) && (sys_state != SPWC_S0)
				&& (state_d == SPWC_S0);
			if (state_d != SPWC_S0) begin
				monitor_on <= 1'b0;
			end else if (sys_state != SPWC_S0) begin
				// Alarm wake leaves the display dark
				monitor_on <= !(is_sleep(sys_state) && wake_rtc_only && !press_valid);
			end else if (press_valid || os_sleep_req) begin
				monitor_on <= 1'b1;
			end
			if (state_d == SPWC_S0) begin
				led_code <= `SPWC_LED_PRIMARY;
			end else if (state_d == SPWC_S3) begin
				led_code <= dual_led ? `SPWC_LED_SECONDARY : `SPWC_LED_OFF;
			end else begin
				led_code <= `SPWC_LED_OFF;
			end
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	sequence s_long_hold;
		press_valid && press_kind == SPWC_PRESS_LONG && ac_good;
	endsequence

	sequence s_s3_to_s0;
		sys_state == SPWC_S3 ##1 sys_state == SPWC_S0;
	endsequence

	sequence s_off_to_s0;
		sys_state == SPWC_S5 ##1 sys_state == SPWC_S0;
	endsequence

	// No switch result pending, so a wake level alone decides the next state
	sequence s_sleep_quiet;
		is_sleep(sys_state) && ac_good && !press_valid;
	endsequence

	a_long_forces_off: assert property (@(posedge clk) disable iff (sys_rst)
		(s_long_hold and (sys_state != SPWC_G3)) |=> sys_state == SPWC_S5)
		else $error("long press did not force soft-off");
	a_short_wakes: assert property (@(posedge clk) disable iff (sys_rst)
		press_valid && press_kind == SPWC_PRESS_SHORT && ac_good && is_sleep(sys_state)
		|=> sys_state == SPWC_S0 && main_power_on)
		else $error("short press did not wake");
	a_short_sleeps: assert property (@(posedge clk) disable iff (sys_rst)
		press_valid && press_kind == SPWC_PRESS_SHORT && ac_good && sys_state == SPWC_S0
		|=> sys_state == ($past(policy_button_off) ? SPWC_S5 : SPWC_S3))
		else $error("short press in working went to wrong state");
	a_mid_press_idle: assert property (@(posedge clk) disable iff (sys_rst)
		press_valid && press_kind == SPWC_PRESS_MID && ac_good && sys_state != SPWC_G3
		&& !wake_any && !os_off_req && !os_sleep_req
		|=> sys_state == $past(sys_state))
		else $error("mid-length press changed state");
	a_radio_ignored: assert property (@(posedge clk) disable iff (sys_rst)
		s_sleep_quiet ##0 (wake_vec == '0 && radio_event)
		|=> sys_state == $past(sys_state))
		else $error("radio event woke the system");
	a_deep_blocks: assert property (@(posedge clk) disable iff (sys_rst)
		deep_standby && sys_state != SPWC_S3 |-> !wake_vec[`SPWC_WK_IR]
		&& !wake_vec[`SPWC_WK_USB])
		else $error("IR or USB wake in deepest standby");
	a_pcie_wake: assert property (@(posedge clk) disable iff (sys_rst)
		is_sleep(sys_state) && !pcie_wake_n && ac_good |=> sys_state == SPWC_S0)
		else $error("PCIe wake ignored");
	a_s3_resume: assert property (@(posedge clk) disable iff (sys_rst)
		s_s3_to_s0 |-> resume_ctx && !cold_boot)
		else $error("S3 wake did not resume context");
	a_led_s3: assert property (@(posedge clk) disable iff (sys_rst)
		sys_state == SPWC_S3 && $stable(sys_state) && $stable(dual_led) |->
		led_code == (dual_led ? `SPWC_LED_SECONDARY : `SPWC_LED_OFF))
		else $error("indicator wrong in S3");
	a_rtc_dark: assert property (@(posedge clk) disable iff (sys_rst)
		is_sleep(sys_state) && wake_rtc_only && !press_valid && ac_good
		|=> sys_state == SPWC_S0 && !monitor_on)
		else $error("monitor powered on alarm wake");
	a_resume_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		resume_ctx |=> !resume_ctx)
		else $error("resume pulse held longer than one cycle");
	a_cold_from_off: assert property (@(posedge clk) disable iff (sys_rst)
		s_off_to_s0 |-> cold_boot && !resume_ctx)
		else $error("soft-off exit did not cold boot");

	// ************************************************
	// Wake source and power-loss checks
	// ************************************************
	// Wake inputs are levels; each must act on the very next edge
	a_lan_wakes: assert property (@(posedge clk) disable iff (sys_rst)
		s_sleep_quiet ##0 lan_wake_frame |=> sys_state == SPWC_S0)
		else $error("network wake frame ignored");
	a_ir_wakes: assert property (@(posedge clk) disable iff (sys_rst)
		s_sleep_quiet ##0 (ir_activity && !deep_standby) |=> sys_state == SPWC_S0)
		else $error("infrared wake ignored");
	a_alarm_wakes_s5: assert property (@(posedge clk) disable iff (sys_rst)
		s_sleep_quiet ##0 (sys_state == SPWC_S5 && rtc_alarm) |=> sys_state == SPWC_S0)
		else $error("alarm did not wake from soft-off");
	// USB stays deaf until the system has run once after AC return
	a_usb_after_off: assert property (@(posedge clk) disable iff (sys_rst)
		after_g3_q && is_sleep(sys_state) |-> !wake_vec[`SPWC_WK_USB])
		else $error("USB woke the system after mechanical off");
	a_ac_loss_g3: assert property (@(posedge clk) disable iff (sys_rst)
		!ac_good |=> sys_state == SPWC_G3 && !main_power_on)
		else $error("AC loss did not reach mechanical off");
	a_restore_on: assert property (@(posedge clk) disable iff (sys_rst)
		sys_state == SPWC_G3 && ac_good && restore_always_on
		|=> sys_state == SPWC_S0 && main_power_on)
		else $error("AC return ignored always-on policy");
endmodule : spwc_ctrl
`default_nettype wire

/* spwc_partner.sv */
// Purpose: Far-side model: power switch and an attached PCIe card
// Assumes: Driven from the bench just after the rising edge
// Notes: Switch is a clean level; no chatter is modelled or driven
`timescale 1ns/1ns
`default_nettype none
module spwc_partner (
	input wire logic clk, // clock
	input wire logic sys_rst, // sync reset
	input wire logic start, // begin a press
	input wire logic [15:0] hold_cyc, // press length in clocks
	input wire logic wake_req, // card asks for wake
	output logic switch_raw, // switch level, high pressed
	output logic busy, // press in progress
	output logic pcie_wake_n // PCIe wake, low active
);
	logic [15:0] left_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			left_q <= 16'h0000;
		end else if (start) begin
			left_q <= hold_cyc;
		end else if (left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
		end
	end
	assign switch_raw = (left_q != 16'h0000);
	assign busy = switch_raw;
	assign pcie_wake_n = ~wake_req;
endmodule : spwc_partner
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the power-state and wake controller
// Assumes: Shortened counts, 1 ms is 4 clocks
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
`include "spwc_regs.svh"
module tb_top
	import spwc_pkg::*;
;
	logic clk, sys_rst, ac_good, os_sleep_req, os_sleep_s4, os_off_req;
	logic policy_button_off, restore_last, restore_always_on, usb_deep_wake_en;
	logic deep_standby, rtc_alarm, lan_wake_frame, usb_activity, ir_activity;
	logic radio_event, dual_led, start, wake_req, switch_raw, busy, pcie_wake_n;
	logic main_power_on, resume_ctx, cold_boot, monitor_on;
	logic [1:0] led_code;
	logic [15:0] hold_cyc;
	spwc_state_t sys_state;
	int num_errors, tests_run, cycles;
	spwc_ctrl #(.TICK_CYC(4), .DEB_MS(2), .SHORT_MS(20), .LONG_MS(30)) DUT (
		.clk(clk), .sys_rst(sys_rst), .ac_good(ac_good), .switch_raw(switch_raw),
		.os_sleep_req(os_sleep_req), .os_sleep_s4(os_sleep_s4), .os_off_req(os_off_req),
		.policy_button_off(policy_button_off), .restore_last(restore_last),
		.restore_always_on(restore_always_on), .usb_deep_wake_en(usb_deep_wake_en),
		.deep_standby(deep_standby), .rtc_alarm(rtc_alarm), .lan_wake_frame(lan_wake_frame),
		.usb_activity(usb_activity), .pcie_wake_n(pcie_wake_n), .ir_activity(ir_activity),
		.radio_event(radio_event), .dual_led(dual_led), .sys_state(sys_state),
		.main_power_on(main_power_on), .resume_ctx(resume_ctx), .cold_boot(cold_boot),
		.monitor_on(monitor_on), .led_code(led_code));
	spwc_partner partner (.clk(clk), .sys_rst(sys_rst), .start(start),
		.hold_cyc(hold_cyc), .wake_req(wake_req), .switch_raw(switch_raw),
		.busy(busy), .pcie_wake_n(pcie_wake_n));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic print_verdict();
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	// Hang guard, well above the longest sequence
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wait_st(input spwc_state_t exp, input int lim);
		for (int i = 0; i < lim && sys_state !== exp; i++) cyc(1);
		chk(sys_state, exp);
	endtask : wait_st
	task automatic press(input int ms);
		hold_cyc = 16'(ms * 4);
		start = 1'b1;
		cyc(1);
		start = 1'b0;
	endtask : press
	task automatic settle();
		for (int i = 0; i < 400 && busy === 1'b1; i++) cyc(1);
		cyc(40);
	endtask : settle
	task automatic sleep(input logic s4);
		os_sleep_s4 = s4;
		os_sleep_req = 1'b1;
		cyc(1);
		os_sleep_req = 1'b0;
		wait_st(s4 ? SPWC_S4 : SPWC_S3, 4);
	endtask : sleep
	task automatic src(input int i, input logic v);
		case (i)
			`SPWC_WK_RTC: rtc_alarm = v;
			`SPWC_WK_LAN: lan_wake_frame = v;
			`SPWC_WK_USB: usb_activity = v;
			`SPWC_WK_PCIE: wake_req = v;
			default: ir_activity = v;
		endcase
	endtask : src
	task automatic t_wake_s3();
		for (int i = `SPWC_WK_RTC; i < `SPWC_WK_N; i++) begin
			sleep(1'b0);
			src(i, 1'b1);
			cyc(1);
			chk(sys_state, SPWC_S0);
			chk(resume_ctx, 1'b1);
			chk(monitor_on, i != `SPWC_WK_RTC);
			src(i, 1'b0);
			cyc(1);
			chk(resume_ctx, 1'b0);
		end
	endtask : t_wake_s3
	task automatic t_led_radio();
		sleep(1'b0);
		dual_led = 1'b1;
		cyc(2);
		chk(led_code, `SPWC_LED_SECONDARY);
		dual_led = 1'b0;
		cyc(2);
		chk(led_code, `SPWC_LED_OFF);
		radio_event = 1'b1;
		cyc(3);
		chk(sys_state, SPWC_S3);
		radio_event = 1'b0;
		press(8);
		settle();
		chk(sys_state, SPWC_S0);
		chk(led_code, `SPWC_LED_PRIMARY);
	endtask : t_led_radio
	task automatic t_deep();
		sleep(1'b1);
		usb_activity = 1'b1;
		cyc(3);
		chk(sys_state, SPWC_S4);
		deep_standby = 1'b1;
		usb_deep_wake_en = 1'b1;
		ir_activity = 1'b1;
		cyc(3);
		chk(sys_state, SPWC_S4);
		ir_activity = 1'b0;
		deep_standby = 1'b0;
		cyc(1);
		chk(sys_state, SPWC_S0);
		chk(cold_boot, 1'b1);
		usb_activity = 1'b0;
		usb_deep_wake_en = 1'b0;
	endtask : t_deep
	task automatic t_press_s0();
		policy_button_off = 1'b0;
		press(8);
		settle();
		chk(sys_state, SPWC_S3);
		press(8);
		settle();
		chk(sys_state, SPWC_S0);
		policy_button_off = 1'b1;
		press(8);
		settle();
		chk(sys_state, SPWC_S5);
		press(8);
		settle();
		chk(sys_state, SPWC_S0);
		os_off_req = 1'b1;
		cyc(1);
		os_off_req = 1'b0;
		chk(sys_state, SPWC_S5);
		rtc_alarm = 1'b1;
		cyc(1);
		chk(sys_state, SPWC_S0);
		chk(monitor_on, 1'b0);
		rtc_alarm = 1'b0;
		press(25);
		settle();
		chk(sys_state, SPWC_S0);
		press(60);
		wait_st(SPWC_S5, 200);
		chk(switch_raw, 1'b1);
		settle();
	endtask : t_press_s0
	task automatic t_ac_loss();
		press(8);
		settle();
		ac_good = 1'b0;
		cyc(2);
		chk(sys_state, SPWC_G3);
		chk(main_power_on, 1'b0);
		restore_always_on = 1'b0;
		restore_last = 1'b1;
		ac_good = 1'b1;
		wait_st(SPWC_S0, 4);
		press(8);
		settle();
		chk(sys_state, SPWC_S5);
		ac_good = 1'b0;
		cyc(2);
		ac_good = 1'b1;
		wait_st(SPWC_S5, 4);
		usb_deep_wake_en = 1'b1;
		usb_activity = 1'b1;
		cyc(3);
		chk(sys_state, SPWC_S5);
		usb_activity = 1'b0;
		usb_deep_wake_en = 1'b0;
	endtask : t_ac_loss
	initial begin
		{ac_good, os_sleep_req, os_sleep_s4, os_off_req, policy_button_off} = 5'h10;
		{restore_last, restore_always_on, usb_deep_wake_en, deep_standby} = 4'h4;
		{rtc_alarm, lan_wake_frame, usb_activity, ir_activity, radio_event} = 5'h00;
		{dual_led, start, wake_req} = 3'h4;
		hold_cyc = 16'h0000;
		num_errors = 0;
		tests_run = 0;
		cycles = 0;
		sys_rst = 1'b1;
		cyc(16);
		sys_rst = 1'b0;
		wait_st(SPWC_S0, 4);
		chk(main_power_on, 1'b1);
		t_wake_s3();
		t_led_radio();
		t_deep();
		t_press_s0();
		t_ac_loss();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
